// ==== tmc_map.vh ====
// Register map, field positions, reset values and timing constants of the timer block.
// Assumes inclusion by the timer design file and its testbench.
`ifndef TMC_MAP_VH
`define TMC_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define TMC_ADDR_CONTROL   12'h418
`define TMC_ADDR_RELOAD    12'h41c
`define TMC_ADDR_CAPTURE   12'h420
`define TMC_ADDR_COUNT     12'h424
`define TMC_ADDR_MODE      12'h428
`define TMC_ADDR_IRQ_STAT  12'h42c
`define TMC_ADDR_IRQ_MASK  12'h430

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define TMC_BIT_OVF        7
`define TMC_BIT_EXF        6
`define TMC_BIT_RX0_SEL    5
`define TMC_BIT_TX0_SEL    4
`define TMC_BIT_EXEN       3
`define TMC_BIT_RUN        2
`define TMC_BIT_CT         1
`define TMC_BIT_CPRL       0

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define TMC_BIT_RX1_SEL    0
`define TMC_BIT_TX1_SEL    1
`define TMC_BIT_TOGOE      2

// ----------------------------------------------------------------
// Interrupt status fields
// ----------------------------------------------------------------
`define TMC_IRQ_OVF        0
`define TMC_IRQ_EXF        1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define TMC_RST_CONTROL    8'h00
`define TMC_RST_MODE       3'h0
`define TMC_RST_RELOAD     16'h0000
`define TMC_TICK_DIV       4

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define TMC_RESP_OKAY      2'b00
`define TMC_RESP_SLVERR    2'b10

`endif

// ==== tmc_edge.v ====
// Falling-edge detector for the external trigger and count inputs.
// Assumes the input is already synchronous to clk.
module tmc_edge (
  input  wire clk,
  input  wire rst,
  input  wire sig_in,
  output wire fall
);

  reg prev_q;

  always @(posedge clk) begin
    if (rst) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= sig_in;
    end
  end

  assign fall = prev_q & ~sig_in;

endmodule

// ==== tmc_tick.v ====
// Divider producing one-cycle timer tick enables.
// Assumes a single clock domain; the tick rate is clk divided by DIV.
module tmc_tick #(
  parameter DIV = 4
) (
  input  wire clk,
  input  wire rst,
  output wire tick
);

  reg [15:0] cnt_q;

  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q == DIV[15:0] - 16'h0001) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign tick = (cnt_q == DIV[15:0] - 16'h0001);

endmodule

// ==== tmc_timer2.v ====
// Timer 2 control, flags, count/capture/reload and AXI4-Lite register slave.
// Assumes synchronous inputs on clk and an AXI4-Lite master on the same clock.
//
// Behaviour
// RULE_01: Overflow sets overflow flag; only software clears.
// RULE_02: No overflow flag while baud select or toggle.
// RULE_03: Enabled trigger fall capture/reload sets external flag.
// RULE_04: External flag requests the shared timer interrupt.
// RULE_05: External flag cleared only by software write.
// RULE_06: Clock select bits route overflow to serial 0.
// RULE_07: Capture mode: trigger fall captures count.
// RULE_08: Reload mode: reload on overflow and trigger fall.
// RULE_09: Baud select forces reload, ignores capture select.
// RULE_10: Capture copies count bytes into capture bytes.
// RULE_11: Reload loads count from reload bytes.
// RULE_12: Run bit starts/stops; select picks clock source.
`include "tmc_map.vh"

module tmc_timer2 #(
  parameter TICK_DIV = `TMC_TICK_DIV
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        external_trigger_input,
  input  wire        count_input,
  output reg         serial0_rx_baud_tick,
  output reg         serial0_tx_baud_tick,
  output reg         serial1_rx_baud_tick,
  output reg         serial1_tx_baud_tick,
  output wire        irq,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [7:0]  ctrl_q;
  reg  [2:0]  mode_q;
  reg  [15:0] count_q;
  reg  [15:0] reload_q;
  reg  [15:0] capture_q;
  reg  [1:0]  irq_stat_q;
  reg  [1:0]  irq_mask_q;
  reg         aw_hold_q;
  reg  [11:0] aw_addr_q;
  reg         w_hold_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;

  wire        tick;
  wire        trig_fall;
  wire        cnt_fall;

  tmc_tick #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  tmc_edge u_edge (
    .clk    (clk),
    .rst    (rst),
    .sig_in (external_trigger_input),
    .fall   (trig_fall)
  );

  // The count pin has its own detector; a pin held low through reset gives one fall after reset, which counts nothing as RUN resets clear.
  tmc_edge u_cnt_edge (
    .clk    (clk),
    .rst    (rst),
    .sig_in (count_input),
    .fall   (cnt_fall)
  );

  function known_addr;
    input [11:0] a;
    begin
      known_addr = (a == `TMC_ADDR_CONTROL) || (a == `TMC_ADDR_RELOAD) ||
                   (a == `TMC_ADDR_CAPTURE) || (a == `TMC_ADDR_COUNT) ||
                   (a == `TMC_ADDR_MODE) || (a == `TMC_ADDR_IRQ_STAT) ||
                   (a == `TMC_ADDR_IRQ_MASK);
    end
  endfunction

  // Byte-lane write enable of one register for the write being answered.
  function wr_lane;
    input        go;
    input [11:0] a;
    input [11:0] reg_a;
    input        lane;
    begin
      wr_lane = go & (a == reg_a) & lane;
    end
  endfunction

  // ----------------------------------------------------------------
  // Counting datapath
  // ----------------------------------------------------------------
  wire run         = ctrl_q[`TMC_BIT_RUN];
  wire exen        = ctrl_q[`TMC_BIT_EXEN];
  wire baud_any0   = ctrl_q[`TMC_BIT_RX0_SEL] | ctrl_q[`TMC_BIT_TX0_SEL];
  wire baud_any1   = mode_q[`TMC_BIT_RX1_SEL] | mode_q[`TMC_BIT_TX1_SEL];
  wire baud_any    = baud_any0 | baud_any1;
  // Only up counting exists; the toggle enable merely gates the overflow flag.
  // Event counting uses falling edges of the count pin instead of the tick.
  wire step        = run & (ctrl_q[`TMC_BIT_CT] ? cnt_fall : tick); // RULE_12
  wire overflow    = step & (count_q == 16'hffff);
  wire capture_md  = ctrl_q[`TMC_BIT_CPRL] & ~baud_any; // RULE_09
  wire ext_event   = exen & trig_fall;
  wire do_capture  = ext_event & capture_md; // RULE_07
  wire do_reload   = overflow | (ext_event & ~capture_md); // RULE_08
  wire ovf_set     = overflow & ~baud_any & ~mode_q[`TMC_BIT_TOGOE]; // RULE_02

  always @(posedge clk) begin
    if (rst) begin
      count_q   <= 16'h0000;
      capture_q <= 16'h0000;
    end else begin
      if (do_capture) begin
        capture_q <= count_q; // RULE_10
      end
      // A capture-mode overflow still wraps through the reload value.
      if (do_reload) begin
        count_q <= reload_q; // RULE_11
      end else if (step) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // Overflow rate drives the serial baud ticks when selected.
  always @(posedge clk) begin
    if (rst) begin
      serial0_rx_baud_tick <= 1'b0;
      serial0_tx_baud_tick <= 1'b0;
      serial1_rx_baud_tick <= 1'b0;
      serial1_tx_baud_tick <= 1'b0;
    end else begin
      serial0_rx_baud_tick <= overflow & ctrl_q[`TMC_BIT_RX0_SEL]; // RULE_06
      serial0_tx_baud_tick <= overflow & ctrl_q[`TMC_BIT_TX0_SEL]; // RULE_06
      serial1_rx_baud_tick <= overflow & mode_q[`TMC_BIT_RX1_SEL];
      serial1_tx_baud_tick <= overflow & mode_q[`TMC_BIT_TX1_SEL];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // A write lands only once address and data are both in hand; the response follows.
  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;

  wire        aw_ok  = aw_hold_q | (s_axi_awvalid & s_axi_awready);
  wire        w_ok   = w_hold_q | (s_axi_wvalid & s_axi_wready);
  wire [11:0] wa     = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  wire [31:0] wd     = w_hold_q ? w_data_q : s_axi_wdata;
  wire [3:0]  ws     = w_hold_q ? w_strb_q : s_axi_wstrb;
  wire        wr_go  = aw_ok & w_ok & ~s_axi_bvalid;
  wire        wr_ctl    = wr_lane(wr_go, wa, `TMC_ADDR_CONTROL, ws[0]);
  wire        wr_ist    = wr_lane(wr_go, wa, `TMC_ADDR_IRQ_STAT, ws[0]);
  wire        wr_mode   = wr_lane(wr_go, wa, `TMC_ADDR_MODE, ws[0]);
  wire        wr_rld_lo = wr_lane(wr_go, wa, `TMC_ADDR_RELOAD, ws[0]);
  wire        wr_rld_hi = wr_lane(wr_go, wa, `TMC_ADDR_RELOAD, ws[1]);
  wire        wr_msk    = wr_lane(wr_go, wa, `TMC_ADDR_IRQ_MASK, ws[0]);

  always @(posedge clk) begin
    if (rst) begin
      aw_hold_q    <= 1'b0;
      aw_addr_q    <= 12'h000;
      w_hold_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TMC_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known_addr(wa) ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_hold_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_hold_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Hardware sets take priority over a software clear in the same cycle,
  // so an event landing on the clearing write is never lost.
  always @(posedge clk) begin
    if (rst) begin
      ctrl_q <= `TMC_RST_CONTROL;
    end else begin
      if (wr_ctl) begin
        ctrl_q <= wd[7:0]; // RULE_05
      end
      if (ovf_set) begin
        ctrl_q[`TMC_BIT_OVF] <= 1'b1; // RULE_01
      end
      if (ext_event) begin
        ctrl_q[`TMC_BIT_EXF] <= 1'b1; // RULE_03
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode, reload and interrupt mask registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      mode_q     <= `TMC_RST_MODE;
      reload_q   <= `TMC_RST_RELOAD;
      irq_mask_q <= 2'b00;
    end else begin
      if (wr_mode) begin
        mode_q <= wd[2:0];
      end
      if (wr_rld_lo) begin
        reload_q[7:0] <= wd[7:0];
      end
      if (wr_rld_hi) begin
        reload_q[15:8] <= wd[15:8];
      end
      if (wr_msk) begin
        irq_mask_q <= wd[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and request
  // ----------------------------------------------------------------
  // Status bits are sticky and apart from the control flags, so software
  // may rewrite the control byte without losing a pending request.
  always @(posedge clk) begin
    if (rst) begin
      irq_stat_q <= 2'b00;
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_ist ? wd[1:0] : 2'b00)) |
                    {ext_event, ovf_set};
    end
  end

  assign irq = |(irq_mask_q & irq_stat_q); // RULE_04

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  // Unmapped reads answer with an error and zero data, so probing the map is harmless.
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `TMC_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= known_addr(s_axi_araddr) ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
      case (s_axi_araddr)
        `TMC_ADDR_CONTROL:  s_axi_rdata <= {24'h000000, ctrl_q};
        `TMC_ADDR_RELOAD:   s_axi_rdata <= {16'h0000, reload_q};
        `TMC_ADDR_CAPTURE:  s_axi_rdata <= {16'h0000, capture_q};
        `TMC_ADDR_COUNT:    s_axi_rdata <= {16'h0000, count_q};
        `TMC_ADDR_MODE:     s_axi_rdata <= {29'h0000000, mode_q};
        `TMC_ADDR_IRQ_STAT: s_axi_rdata <= {30'h0000000, irq_stat_q};
        `TMC_ADDR_IRQ_MASK: s_axi_rdata <= {30'h0000000, irq_mask_q};
        default:            s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== tmc_far_end.sv ====
// Far-side model: trigger and count pins, and a counter of serial 0 receive ticks.
// Assumes the design samples both pins on rising edges of clk.
module tmc_far_end (
  input  wire logic clk,
  input  wire logic rx_tick,
  output logic      trig,
  output logic      cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  int ticks = 0;

  initial begin
    trig = 1'b1;
    cnt  = 1'b1;
  end

  always @(posedge clk) begin
    if (rx_tick) begin
      ticks <= ticks + 1;
    end
  end

  // The low phase spans several clocks so the edge detector cannot miss it.
  task automatic fall();
    @(posedge clk);
    trig <= 1'b0;
    repeat (3) @(posedge clk);
    trig <= 1'b1;
  endtask

  // Each low phase lasts one clock, long enough for the count pin detector.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      cnt <= 1'b0;
      @(posedge clk);
      cnt <= 1'b1;
    end
  endtask
endmodule

// ==== tmc_timer2_assertions.sv ====
// Bus handshake, interrupt and baud tick checks of the timer block.
// Assumes binding to tmc_timer2; sees only its ports.
module tmc_timer2_assertions #(
  parameter TICK_DIV = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq,
  input wire logic serial0_rx_baud_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped early");
  w_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while busy");
  b_cause_a: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awvalid || s_axi_wvalid))
    else $error("response without request");
  reset_quiet_a: assert property ($past(rst) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs busy after reset");
  irq_sticky_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped without a write");
  tick_pulse_a: assert property (serial0_rx_baud_tick && TICK_DIV > 1
    |=> !serial0_rx_baud_tick) else $error("baud tick too long");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(irq));
endmodule

bind tmc_timer2 tmc_timer2_assertions #(.TICK_DIV(TICK_DIV)) chk_i (.clk(clk), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .irq(irq), .serial0_rx_baud_tick(serial0_rx_baud_tick));

// ==== tmc_timer2_tb.sv ====
// Self-checking bench of the timer control block over AXI4-Lite.
// Assumes the design, its checker and the far-side model are compiled first.
`include "tmc_map.vh"
module tmc_timer2_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, awv, wv, br, arv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, d, cv;
  logic [1:0]  r;
  wire         trig, cnt, irq, awr, wr, bv, arr, rv;
  wire  [3:0]  tk;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          n_fail, checks_done, cyc, t0, n_tx, n_s1;

  tmc_far_end far (.clk(clk), .rx_tick(tk[0]), .trig(trig), .cnt(cnt));
  // A short tick period keeps overflow runs brief.
  tmc_timer2 #(.TICK_DIV(2)) dut (.clk(clk), .rst(rst), .external_trigger_input(trig),
    .count_input(cnt), .serial0_rx_baud_tick(tk[0]), .serial0_tx_baud_tick(tk[1]),
    .serial1_rx_baud_tick(tk[2]), .serial1_tx_baud_tick(tk[3]), .irq(irq),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a;
    wd  <= v;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdata;
    r = rresp;
    rr <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end
  always @(posedge clk) begin
    if (tk[1]) n_tx <= n_tx + 1;
    if (tk[2] & tk[3]) n_s1 <= n_s1 + 1;
  end

  initial begin
    {rst, awv, wv, br, arv, rr, awa, ara, wd} = {1'b1, 5'h00, 12'h000, 12'h000, 32'h0};
    {n_fail, checks_done, cyc} = {32'd0, 32'd0, 32'd0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rc(`TMC_ADDR_CONTROL, 32'h00);
    rc(`TMC_ADDR_MODE, 32'h00);
    rc(12'h500, 32'h00);
    chk(r, `TMC_RESP_SLVERR);
    $display("test reset and map done");
    w(`TMC_ADDR_RELOAD, 32'hfffe);
    // The count sits at zero after reset, so a trigger reload lifts it near the top.
    w(`TMC_ADDR_CONTROL, 32'h08);
    far.fall();
    rc(`TMC_ADDR_COUNT, 32'hfffe);
    w(`TMC_ADDR_IRQ_STAT, 32'h03);
    t0 = far.ticks;
    w(`TMC_ADDR_CONTROL, 32'h04);
    repeat (20) @(posedge clk);
    rc(`TMC_ADDR_CONTROL, 32'h84);
    chk(far.ticks, t0);
    rc(`TMC_ADDR_IRQ_STAT, 32'h01);
    w(`TMC_ADDR_IRQ_MASK, 32'h03);
    chk(irq, 1'b1);
    // The first write may race a hardware set, so the flag is cleared twice.
    w(`TMC_ADDR_CONTROL, 32'h00);
    w(`TMC_ADDR_CONTROL, 32'h00);
    rc(`TMC_ADDR_CONTROL, 32'h00);
    w(`TMC_ADDR_IRQ_STAT, 32'h03);
    chk(irq, 1'b0);
    rd(`TMC_ADDR_COUNT);
    cv = d;
    repeat (10) @(posedge clk);
    rc(`TMC_ADDR_COUNT, cv);
    $display("test overflow done");
    w(`TMC_ADDR_CONTROL, 32'h09);
    far.fall();
    repeat (4) @(posedge clk);
    rc(`TMC_ADDR_CONTROL, 32'h49);
    rc(`TMC_ADDR_CAPTURE, cv);
    chk(irq, 1'b1);
    repeat (20) @(posedge clk);
    rc(`TMC_ADDR_CONTROL, 32'h49);
    w(`TMC_ADDR_CONTROL, 32'h00);
    rc(`TMC_ADDR_CONTROL, 32'h00);
    w(`TMC_ADDR_IRQ_STAT, 32'h03);
    $display("test capture done");
    w(`TMC_ADDR_RELOAD, 32'h1234);
    w(`TMC_ADDR_CONTROL, 32'h08);
    far.fall();
    repeat (4) @(posedge clk);
    rc(`TMC_ADDR_COUNT, 32'h1234);
    rc(`TMC_ADDR_CONTROL, 32'h48);
    $display("test reload done");
    w(`TMC_ADDR_RELOAD, 32'hfffe);
    far.fall();
    t0 = far.ticks;
    w(`TMC_ADDR_CONTROL, 32'h35);
    repeat (40) @(posedge clk);
    chk(far.ticks > t0, 1'b1);
    chk(n_tx > 0, 1'b1);
    rc(`TMC_ADDR_CONTROL, 32'h35);
    w(`TMC_ADDR_CONTROL, 32'h00);
    w(`TMC_ADDR_MODE, 32'h04);
    w(`TMC_ADDR_CONTROL, 32'h04);
    repeat (20) @(posedge clk);
    rc(`TMC_ADDR_CONTROL, 32'h04);
    w(`TMC_ADDR_MODE, 32'h03);
    repeat (20) @(posedge clk);
    rc(`TMC_ADDR_CONTROL, 32'h04);
    chk(n_s1 > 0, 1'b1);
    w(`TMC_ADDR_CONTROL, 32'h00);
    w(`TMC_ADDR_MODE, 32'h00);
    $display("test baud done");
    w(`TMC_ADDR_RELOAD, 32'h0100);
    w(`TMC_ADDR_CONTROL, 32'h08);
    far.fall();
    w(`TMC_ADDR_CONTROL, 32'h06);
    far.pulse(3);
    repeat (2) @(posedge clk);
    rc(`TMC_ADDR_COUNT, 32'h0103);
    w(`TMC_ADDR_CONTROL, 32'h00);
    $display("test counter done");
    print_verdict();
  end
endmodule
